// file: design/ccnsc_top.sv
// configuration loader, store control and serial port of the clock chip
`timescale 1ns/1ps
module ccnsc_top
   import ccnsc_pkg::*;
#(
   parameter int         PAGE_W   = 1,
   parameter logic [6:0] I2C_ADDR = 7'h55 // arbitrary
) (
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_srst,
   // i2c port and protocol select
   input  wire logic        i_i2c_sel,
   input  wire logic        i_i2c_scl,
   input  wire logic        i_i2c_sda,
   output logic             o_i2c_sda,
   output logic             o_i2c_sda_oe,
   // spi port
   input  wire logic        i_spi_3wire,
   input  wire logic        i_spi_cs_n,
   input  wire logic        i_spi_sclk,
   input  wire logic        i_spi_mosi,
   input  wire logic        i_spi_sdio,
   output logic             o_spi_dout,
   output logic             o_spi_miso_oe,
   output logic             o_spi_sdio_oe,
   // nonvolatile store burn count
   input  wire logic [1:0]  i_nvm_burns,
   output logic [1:0]       o_nvm_burns,
   // clock path control and status
   input  wire logic [19:0] i_ref_freq_khz,
   input  wire logic        i_phase_slot,
   input  wire logic [3:0]  i_status,
   output logic             o_div_reset,
   output logic             o_ready,
   output logic             o_fb_loop_open,
   output logic             o_hitless_en,
   output logic [7:0]       o_phase_offset,
   output logic             o_interrupt_out_n
);
   localparam int        AW      = PAGE_W + REG_AW;
   localparam int        NW      = AW + BANK_W;
   localparam logic [AW:0] CNT_ONE = {{AW{1'b0}}, 1'b1};

   ccnsc_state_t      state_reg;
   logic [AW:0]       cnt_reg;
   logic [AW-1:0]     cp_addr_reg;
   logic              cp_v_reg;
   logic [1:0]        burns_reg;
   logic              refused_reg;
   logic [PAGE_W-1:0] page_reg;
   logic [7:0]        addr_reg;
   logic [7:0]        ctrl_reg;
   logic [7:0]        phase_reg;
   logic [7:0]        sh_reg;
   logic [7:0]        tx_reg;
   logic [3:0]        bit_reg;
   logic [1:0]        byte_reg;
   logic [3:0]        flags_reg;
   logic [3:0]        mask_reg;
   logic [3:0]        status_q;
   logic              rd_reg;
   logic              act_reg;
   logic              ack_reg;
   logic              ack_pend_reg;
   logic              txen_reg;
   logic              scl_q;
   logic              sda_q;
   logic              sclk_q;
   logic [7:0]        act_q;
   logic [7:0]        nvm_q;
   logic [7:0]        rd_data;
   logic              spec;

   // ---------------------------------------------------------------
   // serial bit engine
   // ---------------------------------------------------------------
   wire spi_on = ~i_i2c_sel & ~i_spi_cs_n;
   wire start  = i_i2c_sel & scl_q & i_i2c_scl & sda_q & ~i_i2c_sda;
   wire stop   = i_i2c_sel & scl_q & i_i2c_scl & ~sda_q & i_i2c_sda;
   wire idle   = i_i2c_sel ? (start | stop) : i_spi_cs_n;
   wire smp    = i_i2c_sel ? (act_reg & ~scl_q & i_i2c_scl)
                           : (spi_on & ~sclk_q & i_spi_sclk);
   wire shf    = i_i2c_sel ? (act_reg & scl_q & ~i_i2c_scl)
                           : (spi_on & sclk_q & ~i_spi_sclk);
   wire din    = i_i2c_sel ? i_i2c_sda
                           : (i_spi_3wire ? i_spi_sdio : i_spi_mosi);
   wire [7:0] rx = {sh_reg[6:0], din};
   wire done   = smp & (bit_reg == BIT_LAST);
   wire wr_go  = done & (byte_reg == BYTE_DATA) & ~rd_reg;
   wire load   = shf & (bit_reg == BIT_FIRST) & rd_reg
                 & (i_i2c_sel ? (byte_reg != BYTE_CMD)
                              : (byte_reg == BYTE_DATA));
   wire pg0    = (page_reg == '0);
   wire burn_go = wr_go & pg0 & (addr_reg == A_CTRL) & rx[C_BURN];
   wire zdm_ok  = i_ref_freq_khz > ZDM_MIN_KHZ;
   wire zdm_on  = ctrl_reg[C_ZDM] & zdm_ok;
   wire copy_end = cnt_reg[AW];

   always_ff @(posedge i_clock) begin
      scl_q  <= i_i2c_scl;
      sda_q  <= i_i2c_sda;
      sclk_q <= i_spi_sclk;
   end

   always_ff @(posedge i_clock) begin
      if (i_srst || idle) begin
         bit_reg      <= BIT_FIRST;
         byte_reg     <= BYTE_CMD;
         rd_reg       <= 1'b0;
         ack_reg      <= 1'b0;
         ack_pend_reg <= 1'b0;
         txen_reg     <= 1'b0;
         act_reg      <= start & ~i_srst;
         sh_reg       <= 8'h00;
         tx_reg       <= 8'h00;
         if (i_srst) begin
            addr_reg <= 8'h00;
         end
      end else begin
         if (smp && bit_reg == BIT_ACK) begin
            bit_reg <= BIT_FIRST;
            if (rd_reg && din) begin
               act_reg <= 1'b0; // host nack ends the read
            end
         end else if (smp) begin
            sh_reg  <= rx;
            bit_reg <= !done ? bit_reg + 4'h1
                             : (i_i2c_sel ? BIT_ACK : BIT_FIRST);
         end
         if (done) begin
            if (byte_reg != BYTE_DATA) begin
               byte_reg <= byte_reg + 2'h1;
            end
            ack_pend_reg <= (byte_reg == BYTE_CMD) | ~rd_reg;
            if (byte_reg == BYTE_CMD) begin
               rd_reg <= i_i2c_sel ? rx[0] : rx[SPI_RD_BIT];
               if (i_i2c_sel && rx[7:1] != I2C_ADDR) begin
                  act_reg      <= 1'b0;
                  ack_pend_reg <= 1'b0;
               end
            end
            if (byte_reg == BYTE_ADDR && (!i_i2c_sel || !rd_reg)) begin
               addr_reg <= rx;
            end
         end
         if (wr_go || load) begin
            addr_reg <= addr_reg + 8'h01;
         end
         if (shf && bit_reg == BIT_ACK) begin
            ack_reg  <= ack_pend_reg;
            txen_reg <= 1'b0;
         end else if (shf && bit_reg == BIT_FIRST) begin
            ack_reg <= 1'b0;
            if (load) begin
               tx_reg   <= rd_data;
               txen_reg <= 1'b1;
            end
         end else if (shf) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
         end
      end
   end

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   always_comb begin
      rd_data = act_q;
      spec    = 1'b1;
      if (addr_reg == A_PAGE) begin
         rd_data = 8'(page_reg);
      end else if (pg0) begin
         case (addr_reg)
            A_ID:    rd_data = ID_VALUE;
            A_FLAGS: rd_data = {4'h0, flags_reg};
            A_MASK:  rd_data = {4'h0, mask_reg};
            A_CTRL:  rd_data = ctrl_reg;
            A_PHASE: rd_data = phase_reg;
            A_STAT:  rd_data = {3'h0, refused_reg, burns_reg,
                                o_hitless_en, o_fb_loop_open};
            default: spec = 1'b0;
         endcase
      end else begin
         spec = 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         page_reg  <= '0;
         ctrl_reg  <= CTRL_RST;
         mask_reg  <= MASK_RST;
         phase_reg <= PHASE_RST;
      end else if (wr_go && addr_reg == A_PAGE) begin
         page_reg <= rx[PAGE_W-1:0];
      end else if (wr_go && pg0) begin
         case (addr_reg)
            A_MASK:  mask_reg  <= rx[3:0];
            A_CTRL:  ctrl_reg  <= rx & CTRL_WMASK;
            A_PHASE: phase_reg <= rx;
            default: ;
         endcase
      end
   end

   // set wins over a write of zero in the same cycle
   wire [3:0] flag_clr = (wr_go && pg0 && addr_reg == A_FLAGS)
                         ? ~rx[3:0] : 4'h0;
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         status_q  <= 4'h0;
         flags_reg <= 4'h0;
      end else begin
         status_q  <= i_status;
         flags_reg <= (flags_reg & ~flag_clr) | (status_q ^ i_status);
      end
   end

   // ---------------------------------------------------------------
   // load and burn sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state_reg   <= ST_FUSE;
         cnt_reg     <= '0;
         cp_addr_reg <= '0;
         cp_v_reg    <= 1'b0;
         burns_reg   <= 2'h0;
         refused_reg <= 1'b0;
      end else begin
         cp_v_reg <= 1'b0;
         case (state_reg)
            ST_FUSE: begin
               // burn count caught after release, not in reset
               burns_reg <= i_nvm_burns;
               cnt_reg   <= '0;
               state_reg <= ST_BOOT;
            end
            ST_BOOT, ST_BURN: begin
               cp_v_reg    <= ~copy_end;
               cp_addr_reg <= cnt_reg[AW-1:0];
               if (copy_end) begin
                  state_reg <= ST_RUN;
                  if (state_reg == ST_BURN) begin
                     burns_reg <= burns_reg + 2'h1;
                  end
               end else begin
                  cnt_reg <= cnt_reg + CNT_ONE;
               end
            end
            ST_RUN: begin
               cnt_reg <= '0;
               // burns run off the core clock alone
               if (burn_go && burns_reg < NVM_MAX_BURNS) begin
                  state_reg <= ST_BURN;
               end else if (burn_go) begin
                  refused_reg <= 1'b1;
               end
            end
            default: state_reg <= ST_FUSE;
         endcase
      end
   end

   wire boot_st = (state_reg == ST_BOOT);
   wire burn_st = (state_reg == ST_BURN);
   wire [AW-1:0] host_a = {page_reg, addr_reg};

   ccnsc_mem #(.AW(AW), .DW(8)) u_active (
      .i_clock (i_clock),
      .i_we    (boot_st ? cp_v_reg
                        : (wr_go & ~spec & state_reg == ST_RUN)),
      .i_waddr (boot_st ? cp_addr_reg : host_a),
      .i_wdata (boot_st ? nvm_q : rx),
      .i_raddr (burn_st ? cnt_reg[AW-1:0] : host_a),
      .o_rdata (act_q)
   );

   // older images stay in the array but are never addressed again
   ccnsc_mem #(.AW(NW), .DW(8)) u_store (
      .i_clock (i_clock),
      .i_we    (burn_st & cp_v_reg),
      .i_waddr ({burns_reg + 2'h1, cp_addr_reg}),
      .i_wdata (act_q),
      .i_raddr ({burns_reg, cnt_reg[AW-1:0]}),
      .o_rdata (nvm_q)
   );

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_i2c_sda   = 1'b0;
   assign o_nvm_burns = burns_reg;

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_div_reset       <= 1'b1;
         o_ready           <= 1'b0;
         o_fb_loop_open    <= 1'b0;
         o_hitless_en      <= 1'b0;
         o_phase_offset    <= PHASE_RST;
         o_interrupt_out_n <= 1'b1;
         o_i2c_sda_oe      <= 1'b0;
         o_spi_dout        <= 1'b0;
         o_spi_miso_oe     <= 1'b0;
         o_spi_sdio_oe     <= 1'b0;
      end else begin
         o_div_reset    <= (state_reg == ST_FUSE) | boot_st;
         o_ready        <= (state_reg == ST_RUN) | burn_st;
         o_fb_loop_open <= zdm_on;
         o_hitless_en   <= ctrl_reg[C_HITLESS] & ~zdm_on;
         if (i_phase_slot) begin
            o_phase_offset <= phase_reg;
         end
         o_interrupt_out_n <= ~|(flags_reg & ~mask_reg);
         o_i2c_sda_oe  <= i_i2c_sel & (ack_reg | (txen_reg & ~tx_reg[7]));
         o_spi_dout    <= tx_reg[7];
         o_spi_miso_oe <= spi_on & txen_reg & ~i_spi_3wire;
         o_spi_sdio_oe <= spi_on & txen_reg & i_spi_3wire;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);

   AST_DIV_RESET: assert property (boot_st |=> o_div_reset)
      else $error("dividers not held in reset during load");
   AST_LOAD_DONE: assert property ($rose(o_ready) |-> $past(copy_end))
      else $error("ready before image copy finished");
   AST_ZDM_ENTER: assert property (zdm_on |=> o_fb_loop_open)
      else $error("zero-delay request did not open loop");
   AST_ZDM_FREQ: assert property (o_fb_loop_open |-> $past(zdm_ok))
      else $error("loop opened with slow reference");
   AST_HITLESS: assert property (o_fb_loop_open |-> !o_hitless_en)
      else $error("hitless switching on in zero-delay mode");
   AST_BURN_LIMIT: assert property (burn_st
      |-> burns_reg < NVM_MAX_BURNS)
      else $error("burn beyond the allowed count");
   AST_BURN_BANK: assert property ($changed(burns_reg)
      |-> $past(state_reg) inside {ST_BURN, ST_FUSE})
      else $error("image index moved without a burn");
   AST_PHASE_SLOT: assert property ($changed(o_phase_offset)
      |-> $past(i_phase_slot))
      else $error("phase moved off a cycle boundary");
   AST_INT_LOW: assert property (|(flags_reg & ~mask_reg)
      |=> !o_interrupt_out_n)
      else $error("unmasked flag did not pull interrupt low");
   AST_SPI_LINES: assert property (o_spi_miso_oe
      |-> !o_spi_sdio_oe && $past(!i_spi_3wire))
      else $error("spi data driven on wrong line");
   AST_PROTO_SEL: assert property ((o_spi_miso_oe || o_spi_sdio_oe)
      |-> $past(!i_i2c_sel))
      else $error("spi output driven in i2c mode");

   COV_BOOT: cover property ($rose(o_ready));
   COV_BURN: cover property (burn_st ##1 !burn_st);
   COV_ZDM: cover property ($rose(o_fb_loop_open));
   COV_SPI_READ: cover property ($rose(o_spi_sdio_oe));
endmodule : ccnsc_top

// file: design/ccnsc_pkg.sv
// package: constants and types of the clock configuration loader
package ccnsc_pkg;
// Function
// - Phase adjust writes reach the outputs only at an output cycle boundary, so the outputs never glitch.
// - The applied skew is not kept across reset and restarts from zero.
// - Zero-delay mode opens the internal feedback loop on software request; one output closes it externally.
// - Zero-delay mode only takes effect while the selected input runs above 128 kHz.
// - Hitless input switching is off whenever zero-delay mode is in effect.
// - All output dividers are held in reset during power-up initialisation.
// - At power-up the latest stored image is copied into the active registers before operation starts.
// - The nonvolatile store takes at most two burns; further burns are refused.
// - After a burn only the newest image is reachable and loaded.
// - The protocol-select pin chooses I2C or SPI and the host must speak the chosen one.
// - SPI works as 4-wire with separate data lines or 3-wire with one shared data line.
// - The register space is split into pages of 256 byte registers.
// - Page 0 holds status flags, masks, controls and identification.
// - Burning the store needs only the normal supplies and clock, no programming voltage.
// - The interrupt output goes low on a change of any unmasked status input and releases when its flag is cleared.

   localparam int         REG_AW        = 8;
   localparam int         BANK_W        = 2;
   localparam logic [1:0] NVM_MAX_BURNS = 2'h2;

   localparam logic [7:0] A_PAGE  = 8'h01;
   localparam logic [7:0] A_ID    = 8'h02;
   localparam logic [7:0] A_FLAGS = 8'h11;
   localparam logic [7:0] A_MASK  = 8'h18;
   localparam logic [7:0] A_CTRL  = 8'h20;
   localparam logic [7:0] A_PHASE = 8'h21;
   localparam logic [7:0] A_STAT  = 8'h22;

   // identification value is arbitrary
   localparam logic [7:0] ID_VALUE   = 8'hA5;

   localparam int         C_ZDM      = 0;
   localparam int         C_HITLESS  = 1;
   localparam int         C_BURN     = 2;
   localparam logic [7:0] CTRL_RST   = 8'h02;
   localparam logic [7:0] CTRL_WMASK = 8'h03;
   localparam logic [3:0] MASK_RST   = 4'h0;
   localparam logic [7:0] PHASE_RST  = 8'h00;

   localparam logic [19:0] ZDM_MIN_KHZ = 20'h00080;

   localparam int         SPI_RD_BIT = 7;
   localparam logic [3:0] BIT_FIRST  = 4'h0;
   localparam logic [3:0] BIT_LAST   = 4'h7;
   localparam logic [3:0] BIT_ACK    = 4'h8;
   localparam logic [1:0] BYTE_CMD   = 2'h0;
   localparam logic [1:0] BYTE_ADDR  = 2'h1;
   localparam logic [1:0] BYTE_DATA  = 2'h2;

   typedef enum logic [3:0] {
      ST_FUSE = 4'h1,
      ST_BOOT = 4'h2,
      ST_RUN  = 4'h4,
      ST_BURN = 4'h8
   } ccnsc_state_t;
endpackage : ccnsc_pkg

// file: design/ccnsc_mem.sv
// simple dual-port byte memory with registered read data
`timescale 1ns/1ps
module ccnsc_mem #(
   parameter int AW = 9,
   parameter int DW = 8
) (
   // clock
   input  wire logic          i_clock,
   // write port
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [DW-1:0] i_wdata,
   // read port
   input  wire logic [AW-1:0] i_raddr,
   output logic      [DW-1:0] o_rdata
);
   logic [DW-1:0] mem_reg [2**AW];

   // no reset: contents must survive i_srst like real storage
   always_ff @(posedge i_clock) begin
      if (i_we) begin
         mem_reg[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_reg[i_raddr];
   end
endmodule : ccnsc_mem

// file: verif/ccnsc_host.sv
// host model: i2c and spi master on the serial configuration port
`timescale 1ns/1ps
module ccnsc_host (
   // clock and device side of the pins
   input  wire logic i_clock,
   input  wire logic i_three_wire,
   input  wire logic i_sda_oe,
   input  wire logic i_dout,
   input  wire logic i_miso_oe,
   input  wire logic i_sdio_oe,
   // host driven pins
   output logic      o_scl,
   output logic      o_sda,
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_mosi,
   output logic      o_sdio
);
   logic sda_low   = 1'b0;
   logic sdio_oe   = 1'b0;
   logic sdio_bit  = 1'b0;
   logic miso_last = 1'b0;
   logic sdio_last = 1'b0;
   logic miso;
   // sda has a pull-up; released spi lines toggle so stale bits never pass
   assign o_sda  = ~(sda_low | i_sda_oe);
   assign miso   = i_miso_oe ? i_dout : ~miso_last;
   assign o_sdio = i_sdio_oe ? i_dout
                             : (sdio_oe ? sdio_bit : ~sdio_last);
   always @(posedge i_clock) begin
      miso_last <= miso;
      sdio_last <= o_sdio;
   end
   initial begin
      o_scl  = 1'b1;
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
   end
   // ---------------------------------------------
   // bus cycles, half period of 8 clocks
   // ---------------------------------------------
   task automatic hp;
      repeat (8) @(negedge i_clock);
   endtask : hp
   task automatic spi_byte(input logic [7:0] tx, input logic drv,
                           output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_mosi   = tx[i];
         sdio_bit = tx[i];
         sdio_oe  = drv & i_three_wire;
         hp();
         rx[i]  = i_three_wire ? o_sdio : miso;
         o_sclk = 1'b1;
         hp();
         o_sclk = 1'b0;
      end
   endtask : spi_byte
   task automatic spi_xfer(input logic rd, input logic [7:0] addr,
                           inout logic [7:0] data);
      logic [7:0] rx;
      o_cs_n = 1'b0;
      hp();
      spi_byte({rd, 7'h00}, 1'b1, rx);
      spi_byte(addr, 1'b1, rx);
      spi_byte(data, ~rd, rx);
      sdio_oe = 1'b0;
      o_cs_n  = 1'b1;
      hp();
      if (rd) data = rx;
   endtask : spi_xfer
   task automatic i2c_start;
      sda_low = 1'b0;
      hp();
      o_scl = 1'b1;
      hp();
      sda_low = 1'b1;
      hp();
      o_scl = 1'b0;
      repeat (2) @(negedge i_clock);
   endtask : i2c_start
   task automatic i2c_byte(input logic [7:0] tx, input logic mack,
                           output logic [7:0] rx, output logic ack);
      logic [8:0] bits;
      logic [8:0] got;
      bits = {tx, mack};
      for (int i = 8; i >= 0; i--) begin
         sda_low = ~bits[i];
         hp();
         o_scl = 1'b1;
         hp();
         got[i] = o_sda;
         o_scl  = 1'b0;
         repeat (2) @(negedge i_clock);
      end
      rx  = got[8:1];
      ack = ~got[0];
   endtask : i2c_byte
   task automatic i2c_xfer(input logic [6:0] dev, input logic rd,
                           input logic [7:0] addr, inout logic [7:0] data,
                           output logic acked);
      logic [7:0] rx;
      logic       a0;
      logic       a1;
      logic       a2;
      logic       nk;
      i2c_start();
      i2c_byte({dev, 1'b0}, 1'b1, rx, a0);
      i2c_byte(addr, 1'b1, rx, a1);
      if (rd) begin
         i2c_start();
         i2c_byte({dev, 1'b1}, 1'b1, rx, a2);
         i2c_byte(8'hFF, 1'b1, data, nk);
      end else begin
         i2c_byte(data, 1'b1, rx, a2);
      end
      sda_low = 1'b1;
      hp();
      o_scl = 1'b1;
      hp();
      sda_low = 1'b0;
      hp();
      acked = a0 & a1 & a2;
   endtask : i2c_xfer
endmodule : ccnsc_host

// file: verif/tb_top.sv
// testbench: register traffic, boot, burn and control checks
`timescale 1ns/1ps
module tb_top;
   import ccnsc_pkg::*;
   localparam logic [6:0] DEV   = 7'h55; // arbitrary
   localparam int         LIMIT = 90000;
   logic        clk        = 1'b0;
   logic        srst       = 1'b1;
   logic        i2c_sel    = 1'b0;
   logic        three_wire = 1'b0;
   logic [1:0]  burns_in   = 2'h0;
   logic [19:0] freq       = 20'h00100;
   logic        slot       = 1'b0;
   logic [3:0]  status     = 4'h0;
   logic [19:0] fq [4]     = '{20'h0007F, 20'h00080, 20'h00081, 20'hFFFFF};
   logic        scl, sda, cs_n, sclk, mosi, sdio, sda_oe, dout, miso_oe;
   logic        sdio_oe, div_reset, ready, fb_open, hitless, int_n, ok;
   logic [1:0]  burns_out;
   logic [7:0]  phase, d, v;
   int          errors   = 0;
   int          compares = 0;
   int          cycles   = 0;
   int          mode     = 1;
   int          seed     = 32'h900E;
   ccnsc_top #(.PAGE_W(1), .I2C_ADDR(DEV)) dut (
      .i_clock(clk), .i_srst(srst), .i_i2c_sel(i2c_sel), .i_i2c_scl(scl),
      .i_i2c_sda(sda), .o_i2c_sda(), .o_i2c_sda_oe(sda_oe),
      .i_spi_3wire(three_wire), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk),
      .i_spi_mosi(mosi), .i_spi_sdio(sdio), .o_spi_dout(dout),
      .o_spi_miso_oe(miso_oe), .o_spi_sdio_oe(sdio_oe),
      .i_nvm_burns(burns_in), .o_nvm_burns(burns_out),
      .i_ref_freq_khz(freq), .i_phase_slot(slot), .i_status(status),
      .o_div_reset(div_reset), .o_ready(ready), .o_fb_loop_open(fb_open),
      .o_hitless_en(hitless), .o_phase_offset(phase),
      .o_interrupt_out_n(int_n));
   ccnsc_host host (.i_clock(clk), .i_three_wire(three_wire),
      .i_sda_oe(sda_oe), .i_dout(dout), .i_miso_oe(miso_oe),
      .i_sdio_oe(sdio_oe), .o_scl(scl), .o_sda(sda), .o_cs_n(cs_n),
      .o_sclk(sclk), .o_mosi(mosi), .o_sdio(sdio));
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         $display("MISMATCH t=%0t run did not finish", $time);
         complete_run();
      end
   end
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic complete_run;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [7:0] exp_ctrl(input logic [1:0] c,
                                           input logic [19:0] f);
      logic fb;
      fb = c[0] & (f > ZDM_MIN_KHZ);
      return {6'h00, c[1] & ~fb, fb};
   endfunction : exp_ctrl
   task automatic use_mode(input int m);
      mode       = m;
      i2c_sel    = (m == 0);
      three_wire = (m == 2);
      @(negedge clk);
   endtask : use_mode
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      logic [7:0] t;
      t = x;
      if (mode == 0) host.i2c_xfer(DEV, 1'b0, a, t, ok);
      else host.spi_xfer(1'b0, a, t);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] x);
      x = 8'h00;
      if (mode == 0) host.i2c_xfer(DEV, 1'b1, a, x, ok);
      else host.spi_xfer(1'b1, a, x);
   endtask : rd
   task automatic boot(input logic [1:0] b);
      int k;
      burns_in = b;
      srst     = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      chk({7'h00, int_n}, 8'h01);
      chk(phase, PHASE_RST);
      k = 0;
      while (ready !== 1'b1 && k < 700) begin
         chk({7'h00, div_reset}, 8'h01);
         @(negedge clk);
         k++;
      end
      @(negedge clk);
      chk({7'h00, ready}, 8'h01);
      chk({7'h00, div_reset}, 8'h00);
   endtask : boot
   task automatic burn_cycle(input logic [7:0] x, input logic [1:0] n);
      int k;
      wr(A_PAGE, 8'h01);
      wr(8'h70, x);
      wr(A_PAGE, 8'h00);
      wr(A_CTRL, 8'h06);
      k = 0;
      while (burns_out !== n && k < 1000) begin
         @(negedge clk);
         k++;
      end
      chk({6'h00, burns_out}, {6'h00, n});
      wr(A_PAGE, 8'h01);
      wr(8'h70, ~x);
      boot(burns_out);
      wr(A_PAGE, 8'h01);
      rd(8'h70, v);
      chk(v, x);
   endtask : burn_cycle
   initial begin
      boot(2'h0);
      for (int m = 0; m < 3; m++) begin
         use_mode(m);
         d = 8'($random(seed));
         wr(A_PAGE, 8'h01);
         wr(8'h40, d);
         wr(A_PAGE, 8'h00);
         wr(8'h40, ~d);
         rd(8'h40, v);
         chk(v, ~d);
         wr(A_PAGE, 8'h01);
         rd(8'h40, v);
         chk(v, d);
         rd(A_PAGE, v);
         chk(v, 8'h01);
         if (m == 0) chk({7'h00, ok}, 8'h01);
      end
      use_mode(0);
      host.i2c_xfer(DEV ^ 7'h01, 1'b0, A_PAGE, d, ok);
      chk({7'h00, ok}, 8'h00);
      use_mode(1);
      host.i2c_xfer(DEV, 1'b0, A_PAGE, d, ok);
      chk({7'h00, ok}, 8'h00);
      wr(A_PAGE, 8'h00);
      rd(A_ID, v);
      chk(v, ID_VALUE);
      for (int i = 0; i < 5; i++) begin
         freq = (i < 4) ? fq[i] : 20'($random(seed));
         for (int c = 0; c < 4; c++) begin
            wr(A_CTRL, 8'(c));
            repeat (3) @(negedge clk);
            v = exp_ctrl(2'(c), freq);
            chk({6'h00, hitless, fb_open}, v);
         end
      end
      rd(A_STAT, v);
      chk({6'h00, v[1:0]}, exp_ctrl(2'h3, freq));
      wr(A_CTRL, CTRL_RST);
      d = 8'($random(seed)) | 8'h01;
      wr(A_PHASE, d);
      repeat (4) @(negedge clk);
      chk(phase, PHASE_RST);
      slot = 1'b1;
      @(negedge clk);
      slot = 1'b0;
      repeat (2) @(negedge clk);
      chk(phase, d);
      wr(A_MASK, 8'h04);
      wr(A_FLAGS, 8'h00);
      status = 4'h4;
      repeat (4) @(negedge clk);
      chk({7'h00, int_n}, 8'h01);
      rd(A_FLAGS, v);
      chk(v, 8'h04);
      status = 4'h5;
      repeat (3) @(negedge clk);
      chk({7'h00, int_n}, 8'h00);
      wr(A_FLAGS, 8'h00);
      repeat (2) @(negedge clk);
      chk({7'h00, int_n}, 8'h01);
      d = 8'($random(seed));
      burn_cycle(d, 2'h1);
      burn_cycle(~d, 2'h2);
      wr(A_PAGE, 8'h00);
      wr(A_CTRL, 8'h06);
      repeat (600) @(negedge clk);
      rd(A_STAT, v);
      chk({5'h00, v[4:2]}, 8'h06);
      chk({6'h00, burns_out}, 8'h02);
      complete_run();
   end
endmodule : tb_top
